// ### verilog/sensor_status_event_flags.v
// read-only status, event and identification words of the angle sensor
// assumes the serial port engine and sensing core run on clk_sys; no synchronisers needed
`include "status_flags_map.vh"

module sensor_status_event_flags #(
    parameter [15:0] PRODUCT_ID = 16'h0a5a, // arbitrary value
    parameter [15:0] MAJOR_REV = 16'h0002, // arbitrary value
    parameter [15:0] MINOR_REV = 16'h0003 // arbitrary value
) (
    input wire clk_sys, // core clock
    input wire sys_rst, // power-on or soft reset, active high
    input wire [7:0] reg_addr, // word address from the port engine
    input wire reg_rd, // one-cycle read strobe
    input wire reg_wr, // one-cycle write strobe, ignored here
    input wire [15:0] reg_wdata, // write data, ignored here
    output reg [15:0] reg_rdata_q, // read data, valid with reg_rvalid_q
    output reg reg_rvalid_q, // one-cycle read answer
    input wire [3:0] power_mode, // current power mode code
    input wire auto_tuning_run, // tuning run in progress
    input wire ack_reset, // one-cycle acknowledge-reset command
    input wire hall_evt, // hall event pulse
    input wire prox_evt, // proximity event pulse
    input wire touch_evt, // touch event pulse
    input wire tuning_evt, // tuning event pulse
    input wire power_evt, // power mode change pulse
    input wire fast_filter, // fast angle filter active
    input wire wheel_still, // wheel detected stationary
    input wire fw_interval_chg, // freewheeling interval change pulse
    input wire fwd_dir, // sampled direction, 1 forward
    input wire interval_chg, // angle interval change pulse
    input wire tch_debounce, // touch channel debouncing
    input wire tch_delta_pos, // touch delta is positive
    input wire tch_dormant, // touch channel dormant
    input wire tch_active, // touch active
    input wire prox_active, // proximity active
    input wire touch_exit_evt, // touch exit pulse
    input wire touch_enter_evt, // touch enter pulse
    input wire fw_active, // freewheeling active
    input wire cycle_end, // one-cycle pulse at end of each sensing cycle
    input wire event_mode, // 1 event mode, 0 streaming
    output reg comm_window_q // one-cycle request to open a communication window
);

    reg [4:0] events_q;
    reg [4:0] events_d;
    reg reset_seen_q;
    reg interval_q;
    reg still_q;
    reg still_prev_q;
    reg touch_exit_q;
    reg touch_enter_q;
    reg [15:0] sys_word;
    reg [15:0] evt_word;
    reg [15:0] hui_word;
    reg [15:0] tch_word;
    reg [15:0] fw_word;
    reg [15:0] rd_word;
    wire [4:0] evt_in;
    wire rd_events;
    wire rd_hall;
    wire rd_fw;

    // read strobes that clear sticky flags
    assign rd_events = reg_rd && (reg_addr == `ADDR_GLOBAL_EVENTS); // see [RULE16]
    assign rd_hall = reg_rd && (reg_addr == `ADDR_ANGLE_UI_FLAGS);
    assign rd_fw = reg_rd && (reg_addr == `ADDR_WHEEL_INERTIA);
    assign evt_in = {hall_evt, prox_evt, touch_evt, tuning_evt, power_evt};

    // a new event in the clearing read's cycle survives, so nothing is lost
    always @* begin
        events_d = rd_events ? evt_in : (events_q | evt_in); // see [RULE3] see [RULE4]
    end

    // sticky flags; set wins over the read clear
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            events_q <= 5'h00;
            reset_seen_q <= 1'b1;
            interval_q <= 1'b0;
            touch_exit_q <= 1'b0;
            touch_enter_q <= 1'b0;
        end else begin
            events_q <= events_d;
            if (ack_reset)
                reset_seen_q <= 1'b0; // see [RULE17]
            interval_q <= interval_chg | (interval_q & ~rd_hall); // see [RULE9]
            touch_exit_q <= touch_exit_evt | (touch_exit_q & ~rd_fw); // see [RULE14]
            touch_enter_q <= touch_enter_evt | (touch_enter_q & ~rd_fw); // see [RULE15]
        end
    end

    // hall stationary: set as the wheel comes to rest, dropped on interval change or motion
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            still_q <= 1'b0;
            still_prev_q <= 1'b0;
        end else begin
            still_prev_q <= wheel_still;
            if (fw_interval_chg || !wheel_still)
                still_q <= 1'b0; // see [RULE7]
            else if (!still_prev_q)
                still_q <= 1'b1;
        end
    end

    // assemble the words; reserved bits read zero
    always @* begin
        sys_word = 16'h0000;
        sys_word[`SYS_PMODE_LSB+3:`SYS_PMODE_LSB] = power_mode; // see [RULE1]
        sys_word[`SYS_RESET_BIT] = reset_seen_q; // see [RULE2]
        sys_word[`SYS_TUNING_BIT] = auto_tuning_run; // see [RULE2]
        evt_word = {11'h000, events_q}; // see [RULE4]
        hui_word = 16'h0000;
        hui_word[`HUI_FAST_FILTER_BIT] = fast_filter; // see [RULE5]
        hui_word[`HUI_HIGH_ACC_BIT] = (power_mode == `PMODE_HIGH_ACC); // see [RULE6]
        hui_word[`HUI_STATIONARY_BIT] = still_q; // see [RULE7]
        hui_word[`HUI_DIRECTION_BIT] = fwd_dir; // see [RULE8]
        hui_word[`HUI_INTERVAL_BIT] = interval_q; // see [RULE9]
        tch_word = 16'h0000;
        tch_word[`TCH_DEBOUNCE_BIT] = tch_debounce; // see [RULE10]
        tch_word[`TCH_DELTA_SIGN_BIT] = tch_delta_pos; // see [RULE11]
        tch_word[`TCH_DORMANT_BIT] = tch_dormant; // see [RULE12]
        tch_word[`TCH_TOUCH_BIT] = tch_active; // see [RULE13]
        tch_word[`TCH_PROX_BIT] = prox_active; // see [RULE13]
        fw_word = 16'h0000;
        fw_word[`FW_TOUCH_EXIT_BIT] = touch_exit_q; // see [RULE14]
        fw_word[`FW_TOUCH_ENTER_BIT] = touch_enter_q; // see [RULE15]
        fw_word[`FW_STATIONARY_BIT] = wheel_still; // see [RULE18]
        fw_word[`FW_ACTIVE_BIT] = fw_active; // see [RULE18]
    end

    // address decode; unknown addresses answer the invalid code
    always @* begin
        case (reg_addr)
            `ADDR_PRODUCT_NUMBER: rd_word = PRODUCT_ID;
            `ADDR_MAJOR_VERSION: rd_word = MAJOR_REV;
            `ADDR_MINOR_VERSION: rd_word = MINOR_REV;
            `ADDR_SYSTEM_STATUS: rd_word = sys_word;
            `ADDR_GLOBAL_EVENTS: rd_word = evt_word;
            `ADDR_ANGLE_UI_FLAGS: rd_word = hui_word;
            `ADDR_TOUCH_STATES: rd_word = tch_word;
            `ADDR_WHEEL_INERTIA: rd_word = fw_word;
            default: rd_word = `INVALID_WORD;
        endcase
    end

    // read answer one cycle after the strobe; writes are accepted and dropped
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata_q <= 16'h0000;
            reg_rvalid_q <= 1'b0;
        end else begin
            reg_rvalid_q <= reg_rd; // see [RULE19]
            if (reg_rd)
                reg_rdata_q <= rd_word;
        end
    end

    // window request: streaming always, event mode only while something is unserviced
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst)
            comm_window_q <= 1'b0;
        else
            comm_window_q <= cycle_end &&
                (!event_mode || (events_q != 5'h00) || reset_seen_q); // see [RULE16] see [RULE17]
    end

endmodule

// ### verilog/status_flags_map.vh
// register offsets, field positions and answer codes of the status and event-flag words
// assumes word-level access from the device's serial port engine, 8-bit word addresses
// Function
// [RULE1] status word bits 5:2 give power mode: 0,1,2,4,8.
// [RULE2] status bit 1 flags reset occurred, bit 0 flags tuning run active.
// [RULE3] events word bit 4 hall, bit 3 proximity, bit 2 touch event.
// [RULE4] events bit 1 tuning event, bit 0 power mode change; bits 15:5 zero.
// [RULE5] hall flags bit 5 follows the fast angle filter being active.
// [RULE6] hall flags bit 3 is high while in high-accuracy power mode.
// [RULE7] hall flags bit 2 shows stationary, cleared on freewheel interval change.
// [RULE8] hall flags bit 1 gives sampled direction, one means forward.
// [RULE9] hall flags bit 0 set when an angle interval change happened.
// [RULE10] touch state bit 10 high while the channel is debouncing.
// [RULE11] touch state bit 9 gives delta sign, one means positive.
// [RULE12] touch state bit 8 high once dormancy timeout put channel dormant.
// [RULE13] touch state bit 1 touch active, bit 0 proximity active.
// [RULE14] freewheel flags bit 3 set when a touch exit event happened.
// [RULE15] freewheel flags bit 2 set when a touch enter event happened.
// [RULE16] reading events word clears pending events; until then ready every cycle.
// [RULE17] reset-occurred flag holds until host acknowledges reset, then clears.
// [RULE18] freewheel bit 1 stationary, bit 0 freewheeling; no interval-change clear.
// [RULE19] all words sixteen bits, read-only; host writes change nothing.
`ifndef STATUS_FLAGS_MAP_VH
`define STATUS_FLAGS_MAP_VH

// word addresses
`define ADDR_PRODUCT_NUMBER 8'h00
`define ADDR_MAJOR_VERSION 8'h01
`define ADDR_MINOR_VERSION 8'h02
`define ADDR_SYSTEM_STATUS 8'h10
`define ADDR_GLOBAL_EVENTS 8'h11
`define ADDR_ANGLE_UI_FLAGS 8'h12
`define ADDR_TOUCH_STATES 8'h13
`define ADDR_WHEEL_INERTIA 8'h14

// answer for an address that holds no word
`define INVALID_WORD 16'h00ee

// power mode codes
`define PMODE_HIGH_ACC 4'h0
`define PMODE_NORMAL 4'h1
`define PMODE_LOW 4'h2
`define PMODE_ULTRA_LOW 4'h4
`define PMODE_HALT 4'h8

// system status fields
`define SYS_PMODE_LSB 2
`define SYS_RESET_BIT 1
`define SYS_TUNING_BIT 0

// global event bits
`define EVT_HALL_BIT 4
`define EVT_PROX_BIT 3
`define EVT_TOUCH_BIT 2
`define EVT_TUNING_BIT 1
`define EVT_POWER_BIT 0

// angle user interface flags
`define HUI_FAST_FILTER_BIT 5
`define HUI_HIGH_ACC_BIT 3
`define HUI_STATIONARY_BIT 2
`define HUI_DIRECTION_BIT 1
`define HUI_INTERVAL_BIT 0

// touch channel state bits
`define TCH_DEBOUNCE_BIT 10
`define TCH_DELTA_SIGN_BIT 9
`define TCH_DORMANT_BIT 8
`define TCH_TOUCH_BIT 1
`define TCH_PROX_BIT 0

// wheel inertia flags
`define FW_TOUCH_EXIT_BIT 3
`define FW_TOUCH_ENTER_BIT 2
`define FW_STATIONARY_BIT 1
`define FW_ACTIVE_BIT 0

`endif

// ### bench/flags_asserts.sv
// port assertions for the status and event-flag words
// assumes it is bound into sensor_status_event_flags, single clk_sys domain
module flags_asserts (
    input wire clk_sys, // core clock
    input wire sys_rst, // async reset, high
    input wire [7:0] reg_addr, // word address
    input wire reg_rd, // read strobe
    input wire [15:0] reg_rdata_q, // read data
    input wire reg_rvalid_q, // read answer
    input wire [3:0] power_mode, // mode code
    input wire auto_tuning_run, // tuning level
    input wire ack_reset, // reset acknowledge
    input wire hall_evt, // hall pulse
    input wire cycle_end, // sensing cycle end
    input wire event_mode, // 1 event mode
    input wire comm_window_q // window request
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // events read with no hall pulse in its cycle, so the hall bit may not stay pending
    sequence rd_ev; reg_rd && reg_addr == 8'h11 && !hall_evt; endsequence
    sequence rd_st; reg_rd && reg_addr == 8'h10; endsequence
    a_read_answer: assert property (reg_rd |=> reg_rvalid_q) else $error("read unanswered");
    a_quiet_valid: assert property (!reg_rd |=> !reg_rvalid_q) else $error("stray answer");
    a_status_mode: assert property (rd_st |=> reg_rdata_q[5:2] == $past(power_mode)
        && reg_rdata_q[0] == $past(auto_tuning_run) && reg_rdata_q[15:6] == 10'h000)
        else $error("status word wrong");
    // the bench leaves one idle cycle between a pulse and the read that follows it
    a_ack_clears: assert property (ack_reset ##[1:2] rd_st |=> !reg_rdata_q[1]) else $error("reset flag kept");
    a_high_acc: assert property (reg_rd && reg_addr == 8'h12 |=>
        reg_rdata_q[3] == ($past(power_mode) == 4'h0)) else $error("accuracy bit wrong");
    a_hall_sticky: assert property (hall_evt ##1 !reg_rd ##1 reg_rd && reg_addr == 8'h11 |=> reg_rdata_q[4]) else $error("hall lost");
    a_event_clear: assert property (rd_ev ##1 !hall_evt ##1 rd_ev |=> reg_rdata_q[15:4] == 12'h000)
        else $error("events not cleared");
    a_bad_addr: assert property (reg_rd && reg_addr == 8'h20 |=> reg_rdata_q == 16'h00ee) else $error("bad answer");
    a_stream_window: assert property (cycle_end && !event_mode |=> comm_window_q) else $error("no window");
endmodule

// ### bench/host_reader.sv
// host-side model of the word port: one read or write at a time
// assumes the bench calls xfer; strobes change at the falling edge
module host_reader (
    input wire clk_sys, // core clock
    input wire reg_rvalid_q, // read answer
    input wire [15:0] reg_rdata_q, // read data
    output logic reg_rd, // read strobe
    output logic reg_wr, // write strobe
    output logic [15:0] reg_wdata, // write data
    output logic [7:0] reg_addr // word address
);
    // idle values at time zero
    initial begin
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_wdata = 16'h0000;
        reg_addr = 8'hff;
    end
    // one-cycle strobe; released address and data go to their inverse so stale values never help
    task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] v,
                        output logic [15:0] d, output logic ok);
        @(negedge clk_sys);
        reg_rd = !w;
        reg_wr = w;
        reg_addr = a;
        reg_wdata = v;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~v;
        ok = reg_rvalid_q ^ w;
        d = reg_rdata_q;
    endtask
endmodule

// ### bench/tb.sv
// self-checking bench for the status and event-flag words
// assumes host_reader as the host and flags_asserts bound to the design
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0, sys_rst = 1'b1, ack_reset = 1'b0, ok, auto_tuning_run = 1'b0;
    logic fw_interval_chg = 1'b0, interval_chg = 1'b0, cycle_end = 1'b0, event_mode = 1'b0;
    logic reg_rd, reg_wr, reg_rvalid_q, comm_window_q;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata_q, d;
    logic [3:0] power_mode = 4'h1;
    logic [4:0] evt = 5'h00; // hall, prox, touch, tuning, power
    logic [1:0] fw = 2'h0; // touch exit, touch enter
    logic [8:0] lv = 9'h000; // live levels
    int err_total = 0, tests_run = 0;
    // 25 MHz core clock
    always #20 clk_sys = ~clk_sys;
    sensor_status_event_flags u_dut (
        .clk_sys, .sys_rst, .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata_q, .reg_rvalid_q,
        .power_mode, .auto_tuning_run, .ack_reset, .hall_evt(evt[4]), .prox_evt(evt[3]),
        .touch_evt(evt[2]), .tuning_evt(evt[1]), .power_evt(evt[0]), .fast_filter(lv[0]),
        .wheel_still(lv[1]), .fw_interval_chg, .fwd_dir(lv[2]), .interval_chg,
        .tch_debounce(lv[3]), .tch_delta_pos(lv[4]), .tch_dormant(lv[5]), .tch_active(lv[6]),
        .prox_active(lv[7]), .touch_exit_evt(fw[1]), .touch_enter_evt(fw[0]),
        .fw_active(lv[8]), .cycle_end, .event_mode, .comm_window_q);
    host_reader u_host (.clk_sys, .reg_rvalid_q, .reg_rdata_q, .reg_rd, .reg_wr, .reg_wdata,
        .reg_addr);
    // expected words from the bench's own view of the inputs
    function automatic logic [15:0] st_w(); return {10'h0, power_mode, 1'b0, auto_tuning_run}; endfunction
    function automatic logic [15:0] hl_w(); return {10'h0, lv[0], 1'b0, power_mode == 4'h0, lv[1], lv[2], 1'b0}; endfunction
    function automatic logic [15:0] tc_w(); return {5'h0, lv[3], lv[4], lv[5], 6'h0, lv[6], lv[7]}; endfunction
    function automatic logic [15:0] fw_w(); return {14'h0, lv[1], lv[8]}; endfunction
    task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
        tests_run++;
        if (s !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    // one read, answer and word both compared
    task automatic rc(input logic [7:0] a, input logic [15:0] e);
        u_host.xfer(1'b0, a, 16'h0000, d, ok);
        check("answer", {15'h0, ok}, 16'h0001);
        check($sformatf("word %h", a), d, e);
    endtask
    // one-cycle pulses on the event inputs
    task automatic pev(input logic [4:0] e, input logic [1:0] f, input logic ic);
        @(negedge clk_sys);
        {evt, fw, interval_chg} = {e, f, ic};
        @(negedge clk_sys);
        {evt, fw, interval_chg} = 8'h00;
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        logic [3:0] modes [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
        void'($urandom(5));
        repeat (12) @(negedge clk_sys);
        sys_rst = 1'b0;
        rc(8'h10, st_w() | 16'h0002);
        @(negedge clk_sys) ack_reset = 1'b1;
        @(negedge clk_sys) ack_reset = 1'b0;
        rc(8'h10, st_w());
        $display("reset flag test done");
        // writes to every word must change nothing
        for (int a = 0; a < 8; a++)
            u_host.xfer(1'b1, a < 3 ? 8'(a) : 8'(a + 13), 16'hffff, d, ok);
        rc(8'h00, 16'h0a5a);
        rc(8'h02, 16'h0003);
        rc(8'h11, 16'h0000);
        rc(8'h20, 16'h00ee);
        $display("write and id test done");
        // all power modes, corners first, then random live levels
        for (int i = 0; i < 20; i++) begin
            power_mode = modes[i % 5];
            lv = i == 0 ? 9'h1ff : i == 1 ? 9'h000 : 9'($urandom);
            auto_tuning_run = 1'($urandom);
            rc(8'h10, st_w());
            rc(8'h12, hl_w());
            rc(8'h13, tc_w());
            rc(8'h14, fw_w());
        end
        $display("live level test done");
        // each sticky bit is set by its pulse and cleared by reading its word
        for (int k = 0; k < 5; k++) begin
            pev(5'(1 << k), 2'h0, 1'b0);
            rc(8'h11, 16'(1 << k));
            rc(8'h11, 16'h0000);
        end
        pev(5'h00, 2'h0, 1'b1);
        rc(8'h12, hl_w() | 16'h0001);
        rc(8'h12, hl_w());
        for (int k = 0; k < 2; k++) begin
            pev(5'h00, 2'(1 << k), 1'b0);
            rc(8'h14, fw_w() | 16'(4 << k));
        end
        $display("sticky event test done");
        // streaming opens a window every cycle; event mode with nothing pending does not
        for (int m = 0; m < 2; m++) begin
            event_mode = m[0];
            @(negedge clk_sys) cycle_end = 1'b1;
            @(negedge clk_sys) cycle_end = 1'b0;
            check("window", {15'h0, comm_window_q}, 16'(1 - m));
        end
        // a freewheel interval change clears only the angle word's stationary bit
        lv[1] = 1'b1;
        @(negedge clk_sys) fw_interval_chg = 1'b1;
        @(negedge clk_sys) fw_interval_chg = 1'b0;
        rc(8'h12, hl_w() & 16'hfffb);
        rc(8'h14, fw_w());
        $display("window and stationary test done");
        print_verdict();
    end
endmodule
bind sensor_status_event_flags flags_asserts u_chk (.*);
